// [hdl/cgor_top.sv]
// Colour gain and offset register bank with AHB-Lite slave port.
// Assumes one clock, synchronous inputs, single word transfers only.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "cgor_defines.svh"
module cgor_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic line_start_i,
  input wire logic [2:0] line_color_i,
  output cgor_pkg::cgor_chan_set_type chan_o
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [4:0][4:0] GAIN_IDX = {
    `CGOR_IDX_C5_GAIN, `CGOR_IDX_C4_GAIN, `CGOR_IDX_C3_GAIN,
    `CGOR_IDX_C2_GAIN, `CGOR_IDX_C1_GAIN};
  localparam logic [4:0][4:0] HI_IDX = {
    `CGOR_IDX_C5_OFS_HI, `CGOR_IDX_C4_OFS_HI, `CGOR_IDX_C3_OFS_HI,
    `CGOR_IDX_C2_OFS_HI, `CGOR_IDX_C1_OFS_HI};
  localparam logic [4:0][4:0] LO_IDX = {
    `CGOR_IDX_C5_OFS_LO, `CGOR_IDX_C4_OFS_LO, `CGOR_IDX_C3_OFS_LO,
    `CGOR_IDX_C2_OFS_LO, `CGOR_IDX_C1_OFS_LO};

  // Reset image of the whole state; offsets sit at mid-scale
  localparam cgor_pkg::cgor_state_type S_RST = '{
    bus: cgor_pkg::cgor_bus_idle,
    idx: 5'h00,
    wr: 1'b0,
    ready: 1'b1,
    rdata: 32'h0000_0000,
    page: `CGOR_PAGE_RST,
    mode: cgor_pkg::cgor_mode_type'(`CGOR_MODE_RST),
    line_color: 3'h0,
    gain: {5{`CGOR_GAIN_RST}},
    ofs_hi: {5{`CGOR_OFS_HI_RST}},
    ofs_lo: {5{`CGOR_OFS_LO_RST}},
    chan: {3{`CGOR_GAIN_RST, `CGOR_OFS_HI_RST, `CGOR_OFS_LO_RST}}
  };

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cgor_pkg::cgor_state_type s_q;
  cgor_pkg::cgor_state_type s_d;
  logic [4:0][`CGOR_OFS_W-1:0] ofs_code;
  logic [`CGOR_GAIN_W-1:0] sel_gain;
  logic [`CGOR_OFS_W-1:0] sel_ofs;
  logic [31:0] rd_word;
  logic page_ok;
  logic per_line;
  cgor_pkg::cgor_chan_type line_chan;

  // ----------------------------------------------------------------
  // Offset code assembly and per-line selection
  // ----------------------------------------------------------------
  // High byte on top, the two stored low bits below
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      ofs_code[i] = {s_q.ofs_hi[i], s_q.ofs_lo[i]};
    end
  end

  // Gain selector for the line's colour
  cgor_mux5 #(
    .WIDTH(`CGOR_GAIN_W)
  ) u_gain_mux (
    .data_i(s_q.gain),
    .sel_i(s_q.line_color),
    .data_o(sel_gain)
  );

  // Offset selector for the line's colour
  cgor_mux5 #(
    .WIDTH(`CGOR_OFS_W)
  ) u_ofs_mux (
    .data_i(ofs_code),
    .sel_i(s_q.line_color),
    .data_o(sel_ofs)
  );

  // Page gating and mode flags
  assign page_ok = (s_q.page == `CGOR_PAGE_COLOR);
  assign per_line = (s_q.mode == cgor_pkg::per_line_color_mode);
  assign line_chan = '{gain: sel_gain, offset: sel_ofs};

  // ----------------------------------------------------------------
  // Read data decode
  // ----------------------------------------------------------------
  // Page 1 registers read zero while another page is selected
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_q.idx)
      `CGOR_IDX_PAGE: rd_word[7:0] = s_q.page;
      `CGOR_IDX_MODE: rd_word[`CGOR_MODE_MSB:`CGOR_MODE_LSB] = s_q.mode;
      `CGOR_IDX_STATUS: begin
        rd_word[`CGOR_STAT_COLOR_MSB:`CGOR_STAT_COLOR_LSB] = s_q.line_color;
        rd_word[`CGOR_STAT_PAGE_OK_BIT] = page_ok;
      end
      default: begin
        for (int i = 0; i < 5; i++) begin
          if (page_ok && s_q.idx == GAIN_IDX[i]) begin
            rd_word[7:0] = s_q.gain[i];
          end
          if (page_ok && s_q.idx == HI_IDX[i]) begin
            rd_word[7:0] = s_q.ofs_hi[i];
          end
          // Upper bits of the low register stay zero
          if (page_ok && s_q.idx == LO_IDX[i]) begin
            rd_word[1:0] = s_q.ofs_lo[i];
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One wait state per transfer so read data comes from a flop
  always_comb begin
    s_d = s_q;
    unique case (s_q.bus)
      cgor_pkg::cgor_bus_idle: begin
        if (hsel_i && hready_i && htrans_i[1]) begin
          s_d.bus = cgor_pkg::cgor_bus_access;
          s_d.idx = haddr_i[`CGOR_ADDR_IDX_MSB:`CGOR_ADDR_IDX_LSB];
          s_d.wr = hwrite_i;
          s_d.ready = 1'b0;
        end
      end
      cgor_pkg::cgor_bus_access: begin
        s_d.bus = cgor_pkg::cgor_bus_idle;
        s_d.ready = 1'b1;
        if (!s_q.wr) begin
          s_d.rdata = rd_word;
        end else begin
          // Page register and mode are reachable from any page
          if (s_q.idx == `CGOR_IDX_PAGE) begin
            s_d.page = hwdata_i[7:0];
          end
          if (s_q.idx == `CGOR_IDX_MODE) begin
            s_d.mode = cgor_pkg::cgor_mode_type'(hwdata_i[`CGOR_MODE_MSB:`CGOR_MODE_LSB]);
          end
          for (int i = 0; i < 5; i++) begin
            if (page_ok && s_q.idx == GAIN_IDX[i]) begin
              s_d.gain[i] = hwdata_i[7:0];
            end
            if (page_ok && s_q.idx == HI_IDX[i]) begin
              s_d.ofs_hi[i] = hwdata_i[7:0];
            end
            // Bits seven to two are dropped, not stored
            if (page_ok && s_q.idx == LO_IDX[i]) begin
              s_d.ofs_lo[i] = hwdata_i[1:0];
            end
          end
        end
      end
    endcase

    // Line colour caught at the line start; bad codes keep the last one
    if (line_start_i && line_color_i < `CGOR_NUM_COLORS) begin
      s_d.line_color = line_color_i;
    end

    // Per-line mode feeds every input from the selected colour
    if (per_line) begin
      s_d.chan.red = line_chan;
      s_d.chan.green = line_chan;
      s_d.chan.blue = line_chan;
    end else begin
      // Colours 4 and 5 play no part here
      s_d.chan.red = '{gain: s_q.gain[0], offset: ofs_code[0]};
      s_d.chan.green = '{gain: s_q.gain[1], offset: ofs_code[1]};
      s_d.chan.blue = '{gain: s_q.gain[2], offset: ofs_code[2]};
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops, except hresp_o which is tied low
  assign hrdata_o = s_q.rdata;
  assign hreadyout_o = s_q.ready;
  assign hresp_o = 1'b0;
  assign chan_o = s_q.chan;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cgor_cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // Helper: set once a write has completed since reset
  logic wr_seen_q;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_seen_q <= 1'b0;
    end else if (s_q.bus == cgor_pkg::cgor_bus_access && s_q.wr) begin
      wr_seen_q <= 1'b1;
    end
  end

  // Address phase taken by this slave
  sequence s_addr_phase;
    s_q.bus == cgor_pkg::cgor_bus_idle && hsel_i && hready_i && htrans_i[1];
  endsequence

  // One wait cycle, then the answer
  sequence s_answer;
    !hreadyout_o ##1 hreadyout_o;
  endsequence

  // Write data phase aimed at colour 4 gain
  sequence s_c4_gain_write;
    s_q.bus == cgor_pkg::cgor_bus_access && s_q.wr && s_q.idx == `CGOR_IDX_C4_GAIN;
  endsequence

  a_bus_one_wait: assert property (s_addr_phase |=> s_answer)
    else $error("transfer answer not after one wait state");

  a_per_line_gain: assert property (
    per_line |=> chan_o.red.gain == $past(s_q.gain[s_q.line_color]))
    else $error("per-line gain is not the line colour's byte");

  a_per_line_ofs: assert property (
    per_line |=> chan_o.blue.offset ==
      {$past(s_q.ofs_hi[s_q.line_color]), $past(s_q.ofs_lo[s_q.line_color])})
    else $error("per-line offset code misassembled");

  a_fixed_gain_ign: assert property (
    (!per_line && !$past(per_line) && $stable(s_q.gain[2:0])) |=> $stable(chan_o.blue.gain))
    else $error("fixed mode gain moved without colour 1-3 change");

  a_fixed_ofs_map: assert property (
    !per_line |=> chan_o.red.offset == $past(ofs_code[0]) &&
      chan_o.green.offset == $past(ofs_code[1]) && chan_o.blue.offset == $past(ofs_code[2]))
    else $error("fixed mode offset map wrong");

  a_fixed_ofs_ign: assert property (
    (!per_line && !$past(per_line) && $stable(ofs_code[2:0])) |=> $stable(chan_o.red.offset))
    else $error("fixed mode offset moved by colour 4 or 5");

  a_ofs_reset_mid: assert property (
    !wr_seen_q |-> ofs_code[4] == 10'h200 && ofs_code[0] == 10'h200)
    else $error("offset not mid-scale after reset");

  a_gain_reset_val: assert property (
    !wr_seen_q |-> s_q.gain[3] == 8'h54 && s_q.gain[4] == 8'h54)
    else $error("colour 4 or 5 gain not at reset value");

  a_fixed_gain_map: assert property (
    !per_line |=> chan_o.red.gain == $past(s_q.gain[0]) && chan_o.green.gain == $past(s_q.gain[1]))
    else $error("fixed mode gain map wrong");

  a_page_gate: assert property (
    (s_c4_gain_write and !page_ok) |=> $stable(s_q.gain[3]))
    else $error("write passed while page 1 not selected");

  a_page_write: assert property (
    (s_c4_gain_write and page_ok) |=> s_q.gain[3] == $past(hwdata_i[7:0]))
    else $error("page 1 write not stored");

  a_lo_upper_zero: assert property (
    (s_q.bus == cgor_pkg::cgor_bus_access && !s_q.wr && s_q.idx == `CGOR_IDX_C1_OFS_LO)
      |=> hrdata_o[31:2] == 30'h0000_0000)
    else $error("low offset register upper bits not zero");

  a_lo_write_trim: assert property (
    (s_q.bus == cgor_pkg::cgor_bus_access && s_q.wr && page_ok && s_q.idx == `CGOR_IDX_C1_OFS_LO)
      |=> s_q.ofs_lo[0] == $past(hwdata_i[1:0]))
    else $error("low offset write not trimmed to two bits");

  a_page_read_zero: assert property (
    (s_q.bus == cgor_pkg::cgor_bus_access && !s_q.wr && !page_ok && s_q.idx <= `CGOR_IDX_C5_OFS_LO)
      |=> hrdata_o == 32'h0000_0000)
    else $error("hidden page register read not zero");

  a_bad_color_keep: assert property (
    (line_start_i && line_color_i >= `CGOR_NUM_COLORS) |=> $stable(s_q.line_color))
    else $error("invalid line colour was latched");

  a_per_line_same: assert property (
    per_line |=> chan_o.red == chan_o.green && chan_o.green == chan_o.blue)
    else $error("per-line inputs differ");

endmodule : cgor_top

// [hdl/cgor_defines.svh]
// Constants of the colour gain and offset register bank: offsets, fields, resets.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CGOR_DEFINES_SVH
`define CGOR_DEFINES_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define CGOR_IDX_C1_GAIN 5'h00
`define CGOR_IDX_C2_GAIN 5'h01
`define CGOR_IDX_C3_GAIN 5'h02
`define CGOR_IDX_C4_GAIN 5'h03
`define CGOR_IDX_C5_GAIN 5'h04
`define CGOR_IDX_C1_OFS_HI 5'h05
`define CGOR_IDX_C1_OFS_LO 5'h06
`define CGOR_IDX_C2_OFS_HI 5'h07
`define CGOR_IDX_C2_OFS_LO 5'h08
`define CGOR_IDX_C3_OFS_HI 5'h09
`define CGOR_IDX_C3_OFS_LO 5'h0A
`define CGOR_IDX_C4_OFS_HI 5'h0B
`define CGOR_IDX_C4_OFS_LO 5'h0C
`define CGOR_IDX_C5_OFS_HI 5'h0D
`define CGOR_IDX_C5_OFS_LO 5'h0E
`define CGOR_IDX_STATUS 5'h1D
`define CGOR_IDX_MODE 5'h1E
`define CGOR_IDX_PAGE 5'h1F

// ----------------------------------------------------------------
// Fields and widths
// ----------------------------------------------------------------
`define CGOR_GAIN_W 8
`define CGOR_OFS_W 10
`define CGOR_ADDR_IDX_LSB 2
`define CGOR_ADDR_IDX_MSB 6
`define CGOR_MODE_LSB 0
`define CGOR_MODE_MSB 1
`define CGOR_STAT_COLOR_LSB 0
`define CGOR_STAT_COLOR_MSB 2
`define CGOR_STAT_PAGE_OK_BIT 8
`define CGOR_NUM_COLORS 3'h5

// ----------------------------------------------------------------
// Reset values and page code
// ----------------------------------------------------------------
`define CGOR_GAIN_RST 8'h54
`define CGOR_OFS_HI_RST 8'h80
`define CGOR_OFS_LO_RST 2'h0
`define CGOR_PAGE_RST 8'h00
`define CGOR_PAGE_COLOR 8'h01
`define CGOR_MODE_RST 2'h0

`endif

// [hdl/cgor_pkg.sv]
// Types of the colour gain and offset register bank.
// Assumes the constants header is on the include path.
package cgor_pkg;
  `include "cgor_defines.svh"

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic {cgor_bus_idle, cgor_bus_access} cgor_bus_type;
  typedef enum logic [1:0] {
    per_line_color_mode,
    fixed_channel_mode_b,
    fixed_channel_mode_2,
    fixed_channel_mode_3
  } cgor_mode_type;

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`CGOR_GAIN_W-1:0] gain;
    logic [`CGOR_OFS_W-1:0] offset;
  } cgor_chan_type;

  typedef struct packed {
    cgor_chan_type red;
    cgor_chan_type green;
    cgor_chan_type blue;
  } cgor_chan_set_type;

  typedef struct packed {
    cgor_bus_type bus;
    logic [4:0] idx;
    logic wr;
    logic ready;
    logic [31:0] rdata;
    logic [7:0] page;
    cgor_mode_type mode;
    logic [2:0] line_color;
    logic [4:0][7:0] gain;
    logic [4:0][7:0] ofs_hi;
    logic [4:0][1:0] ofs_lo;
    cgor_chan_set_type chan;
  } cgor_state_type;
endpackage : cgor_pkg

// [hdl/cgor_mux5.sv]
// Five-way selector of one colour's setting.
// Assumes the selector is kept in 0 to 4 by its user.
`timescale 1ns/1ns
module cgor_mux5 #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic [4:0][WIDTH-1:0] data_i,
  input wire logic [2:0] sel_i,
  output logic [WIDTH-1:0] data_o
);
  // Codes above four fall back to colour 1 rather than X
  always_comb begin
    unique case (sel_i)
      3'h1: data_o = data_i[1];
      3'h2: data_o = data_i[2];
      3'h3: data_o = data_i[3];
      3'h4: data_o = data_i[4];
      default: data_o = data_i[0];
    endcase
  end
endmodule : cgor_mux5

// [verif/cgor_top_bench.sv]
// Self-checking bench of the colour gain and offset register bank.
// Assumes the design files and cgor_defines.svh are compiled before it.
`timescale 1ns/1ns
`include "cgor_defines.svh"
module cgor_top_bench;
  // ----------------------------------------------------------------
  // Signals and expected register image
  // ----------------------------------------------------------------
  logic core_clk_i, rst_i, hsel, hwrite, hresp, hreadyout, line_start;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, line_color;
  cgor_pkg::cgor_chan_set_type chan;
  logic [7:0] gain_v [5];
  logic [7:0] hi_v [5];
  logic [1:0] lo_v [5];
  logic [31:0] rd;
  int num_errors, cmp_count;

  cgor_top cgor_top_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .line_start_i(line_start),
    .line_color_i(line_color), .chan_o(chan));

  // 50 MHz clock
  initial begin
    core_clk_i = 1'h0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // Reporting and comparisons
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word

  task automatic check_chan(input string name, input cgor_pkg::cgor_chan_type exp,
                            input cgor_pkg::cgor_chan_type got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check_chan

  function automatic cgor_pkg::cgor_chan_type exp_chan(input int c);
    exp_chan.gain = gain_v[c];
    exp_chan.offset = {hi_v[c], lo_v[c]};
  endfunction : exp_chan

  // Colour indices expected on red, green and blue
  task automatic check_all(input int r, input int g, input int b);
    check_chan("red", exp_chan(r), chan.red);
    check_chan("green", exp_chan(g), chan.green);
    check_chan("blue", exp_chan(b), chan.blue);
  endtask : check_all

  // Expected read-back of indices 0x00 to 0x0E
  function automatic logic [31:0] reg_exp(input logic [4:0] idx);
    int k;
    if (idx < 5'h05) begin
      return {24'h0, gain_v[idx]};
    end
    k = (int'(idx) - 5) / 2;
    if (idx[0]) begin
      return {24'h0, hi_v[k]};
    end
    return {30'h0, lo_v[k]};
  endfunction : reg_exp

  // ----------------------------------------------------------------
  // Bus master and line driver
  // ----------------------------------------------------------------
  // Bounded wait for hready high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk_i);
    while (hreadyout !== 1'h1) begin
      n++;
      if (n > 20) begin
        num_errors++;
        $display("ERROR hready expected 1 seen stuck low");
        stop_test();
      end
      @(posedge core_clk_i);
    end
  endtask : wait_ready

  // One single-word transfer; read data is taken at the closing edge
  task automatic bus_xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wdata,
                          output logic [31:0] rdata);
    @(posedge core_clk_i);
    hsel <= 1'h1;
    haddr <= {25'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wdata;
    wait_ready();
    rdata = hrdata;
  endtask : bus_xfer

  task automatic wr_reg(input logic [4:0] idx, input logic [31:0] data);
    logic [31:0] unused;
    bus_xfer(1'h1, idx, data, unused);
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [4:0] idx, input logic [31:0] exp);
    bus_xfer(1'h0, idx, 32'h0, rd);
    check_word(name, exp, rd);
    check_word("hresp", 32'h0, {31'h0, hresp});
  endtask : rd_chk

  // Let a setting change reach the channel outputs
  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask : settle

  // One-cycle line start; outputs follow one edge after it is taken
  task automatic line_pulse(input logic [2:0] c);
    @(posedge core_clk_i);
    line_start <= 1'h1;
    line_color <= c;
    @(posedge core_clk_i);
    line_start <= 1'h0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : line_pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, line_start, htrans, line_color, haddr, hwdata} = '0;
    hsize = 3'h2;
    rst_i = 1'h1;
    num_errors = 0;
    cmp_count = 0;
    for (int c = 0; c < 5; c++) begin
      gain_v[c] = 8'h54;
      hi_v[c] = 8'h80;
      lo_v[c] = 2'h0;
    end
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'h0;
    #1;
    check_all(0, 0, 0);
    // Page gate: page 0 hides the bank, so the write must be lost
    wr_reg(`CGOR_IDX_C4_GAIN, 32'h11);
    rd_chk("gain4_page0", `CGOR_IDX_C4_GAIN, 32'h0);
    wr_reg(`CGOR_IDX_PAGE, 32'h1);
    rd_chk("page", `CGOR_IDX_PAGE, 32'h1);
    for (int i = 0; i < 15; i++) begin
      rd_chk("reset_value", i[4:0], reg_exp(i[4:0]));
    end
    $display("test reset_and_page done");
    // Distinct settings per colour; low writes set the unused bits too
    for (int c = 0; c < 5; c++) begin
      gain_v[c] = 8'hC1 + 8'(c);
      hi_v[c] = 8'h3A + 8'(c * 17);
      lo_v[c] = c[1:0] ^ 2'h2;
      wr_reg(c[4:0], {24'h0, gain_v[c]});
      wr_reg(5'(5 + 2 * c), {24'h0, hi_v[c]});
      wr_reg(5'(6 + 2 * c), {24'hFFFFFF, 6'h3F, lo_v[c]});
    end
    for (int i = 0; i < 15; i++) begin
      rd_chk("readback", i[4:0], reg_exp(i[4:0]));
    end
    $display("test register_access done");
    // Per-line colour mode: every colour line selects its own settings
    for (int c = 0; c < 5; c++) begin
      line_pulse(c[2:0]);
      check_all(c, c, c);
    end
    rd_chk("status", `CGOR_IDX_STATUS, 32'h104);
    line_pulse(3'h5);
    check_all(4, 4, 4);
    $display("test per_line_mode done");
    // Fixed-channel modes: colours 1 to 3 on red, green, blue
    for (int m = 1; m < 4; m++) begin
      wr_reg(`CGOR_IDX_MODE, 32'(m));
      settle();
      check_all(0, 1, 2);
      rd_chk("mode", `CGOR_IDX_MODE, 32'(m));
      line_pulse(3'h3);
      check_all(0, 1, 2);
    end
    gain_v[3] = 8'h0F;
    hi_v[4] = 8'hF0;
    wr_reg(`CGOR_IDX_C4_GAIN, 32'h0F);
    wr_reg(`CGOR_IDX_C5_OFS_HI, 32'hF0);
    gain_v[1] = 8'h5A;
    wr_reg(`CGOR_IDX_C2_GAIN, 32'h5A);
    settle();
    check_all(0, 1, 2);
    $display("test fixed_modes done");
    // Unmapped index and a page switch away from the bank
    rd_chk("unmapped", 5'h10, 32'h0);
    wr_reg(`CGOR_IDX_PAGE, 32'h2);
    rd_chk("status_page2", `CGOR_IDX_STATUS, 32'h3);
    wr_reg(`CGOR_IDX_C1_GAIN, 32'h77);
    rd_chk("gain1_page2", `CGOR_IDX_C1_GAIN, 32'h0);
    wr_reg(`CGOR_IDX_PAGE, 32'h1);
    rd_chk("gain1_kept", `CGOR_IDX_C1_GAIN, {24'h0, gain_v[0]});
    $display("test page_gate done");
    stop_test();
  end
endmodule : cgor_top_bench
